/* rtl/cache_ctrl_pkg.sv */
/*
 * constants, encodings and types shared by the external sram cache controller.
 * assumes a 25-bit byte address space and sram data sixteen bits wide.
 */
package cache_ctrl_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int CADDR_W = 16;
    localparam int TAG_ENTRIES = 2048;
    localparam int LOC_W = 11;
    localparam int LINE_W = 4;
    localparam int LINES_PER_BLOCK = 16;
    localparam int TAG_W = 20;
    localparam int MAX_WAYS = 4;
    localparam int AGE_W = 2;
    localparam int BLOCK_LSB = 5;
    localparam int LINE_LSB = 1;
    localparam int LOG2_BLOCKS_MIN = 9;

    // ****************************************************************
    // configuration encodings
    // ****************************************************************
    localparam logic [1:0] SIZE_16K = 2'h0;
    localparam logic [1:0] SIZE_32K = 2'h1;
    localparam logic [1:0] SIZE_64K = 2'h2;
    localparam logic [1:0] ASSOC_DIRECT = 2'h0;
    localparam logic [1:0] ASSOC_TWO = 2'h1;
    localparam logic [1:0] ASSOC_FOUR = 2'h2;

    // ****************************************************************
    // reset values and timing
    // ****************************************************************
    localparam logic RESET_ENABLE = 1'b0;
    localparam logic [1:0] RESET_SIZE = SIZE_16K;
    localparam logic [1:0] RESET_ASSOC = ASSOC_DIRECT;
    localparam logic [AGE_W-1:0] RESET_AGE = 2'h0;
    localparam logic [LINES_PER_BLOCK-1:0] RESET_VALID = 16'h0000;
    localparam int SRAM_READ_CYCLES = 3;
    localparam logic [1:0] SRAM_READ_LAST = 2'(SRAM_READ_CYCLES - 1);

    typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_SRAM_RD, ST_MEM, ST_FILL} state_t;

endpackage : cache_ctrl_pkg

/* rtl/cache_lru_update.sv */
/*
 * least-recently-used age update for the ways of one set.
 * assumes ages start equal; the saturating update makes them distinct as ways fill.
 */
`timescale 1ns/10ps
module cache_lru_update import cache_ctrl_pkg::*; (
    // set ages
    input wire logic [AGE_W-1:0] ages [MAX_WAYS],
    input wire logic [1:0] touchWay,
    input wire logic [2:0] wayCount,
    // updated ages
    output logic [AGE_W-1:0] nextAges [MAX_WAYS]
);

    logic [AGE_W-1:0] maxAge;

    always_comb begin
        maxAge = AGE_W'(wayCount - 3'h1);
        for (int w = 0; w < MAX_WAYS; w++) begin
            if (3'(w) >= wayCount) begin
                nextAges[w] = ages[w];
            end else if (2'(w) == touchWay) begin
                nextAges[w] = RESET_AGE;
            end else if (ages[w] <= ages[touchWay] && ages[w] < maxAge) begin
                nextAges[w] = ages[w] + 2'h1;
            end else begin
                nextAges[w] = ages[w];
            end
        end
    end

endmodule : cache_lru_update

/* rtl/cache_way_select.sv */
/*
 * tag comparators for the ways of one set: hit detection and victim choice.
 * assumes tags, line valids and ages are read out of the tag store by the caller.
 */
`timescale 1ns/10ps
module cache_way_select import cache_ctrl_pkg::*; (
    // set contents
    input wire logic [TAG_W-1:0] wayTag [MAX_WAYS],
    input wire logic [MAX_WAYS-1:0] wayLineValid,
    input wire logic [MAX_WAYS-1:0] wayAnyValid,
    input wire logic [AGE_W-1:0] wayAge [MAX_WAYS],
    input wire logic [2:0] wayCount,
    // request
    input wire logic [TAG_W-1:0] reqTag,
    // result
    output logic hit,
    output logic [1:0] hitWay,
    output logic [1:0] victimWay,
    output logic victimHasBlock
);

    logic foundMatch;
    logic foundEmpty;
    logic [AGE_W-1:0] bestAge;
    logic [1:0] matchWay;
    logic [1:0] emptyWay;
    logic [1:0] oldWay;

    always_comb begin
        hit = 1'b0;
        hitWay = 2'h0;
        foundMatch = 1'b0;
        foundEmpty = 1'b0;
        matchWay = 2'h0;
        emptyWay = 2'h0;
        oldWay = 2'h0;
        bestAge = 2'h0;
        for (int w = 0; w < MAX_WAYS; w++) begin
            if (3'(w) < wayCount) begin
                // tag plus status compare per way
                if (wayAnyValid[w] && wayTag[w] == reqTag) begin
                    if (!foundMatch) begin
                        matchWay = 2'(w);
                    end
                    foundMatch = 1'b1;
                    if (wayLineValid[w]) begin
                        hit = 1'b1;
                        hitWay = 2'(w);
                    end
                end
                if (!wayAnyValid[w] && !foundEmpty) begin
                    foundEmpty = 1'b1;
                    emptyWay = 2'(w);
                end
                // oldest way wins, lowest index on ties
                if (w == 0 || wayAge[w] > bestAge) begin
                    bestAge = wayAge[w];
                    oldWay = 2'(w);
                end
            end
        end
        victimHasBlock = foundMatch;
        if (foundMatch) begin
            victimWay = matchWay;
        end else if (foundEmpty) begin
            victimWay = emptyWay;
        end else begin
            victimWay = oldWay;
        end
    end

endmodule : cache_way_select

/* rtl/sram_cache_ctrl.sv */
/*
 * external sram cache controller: tag store, lookup, fill and write-through.
 * assumes the processor side and the main memory port run on clk, and
 * that the sram read data pins are asynchronous to it.
 */
// How it works
// - cache is 16K, 32K or 64K bytes from one, two or four srams.
// - dedicated 16-bit address bus and 16-bit data bus to the srams.
// - own sram write strobe and read strobe, no glue logic needed.
// - separate upper and lower byte selects for the cache array.
// - a line is two bytes; one tag entry covers sixteen lines.
// - 2048 tag entries, organised direct, two-way or four-way.
// - direct mapping puts every address in exactly one cache location.
// - at 64K, two-way uses two banks of 1024, four-way four banks of 512.
// - every associativity works with any sram count.
// - misses replace the least recently used way of the set.
// - always write-through: every write also goes to main memory.
// - tag lookup comes before the sram read; read hits start no memory transfer.
// - a miss starts the memory transfer at once, no extra cycle.
// - sram selects stay off while a main memory access runs, except in the first memory cycle of a write hit, which writes the sram.
// - software enables or disables the cache.
// - software picks size and associativity; addressing remaps to match.
// - each tag entry holds tag and status bits, compared per request.
`timescale 1ns/10ps
module sram_cache_ctrl import cache_ctrl_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // software configuration
    input wire logic cacheEnable,
    input wire logic [1:0] cacheSize,
    input wire logic [1:0] assocMode,
    // processor request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [1:0] reqByteEn,
    input wire logic [DATA_W-1:0] reqWdata,
    output logic respValid,
    output logic [DATA_W-1:0] respData,
    output logic respHit,
    // main memory port
    output logic memReqValid,
    output logic memWrite,
    output logic [ADDR_W-1:0] memAddr,
    output logic [1:0] memByteEn,
    output logic [DATA_W-1:0] memWdata,
    input wire logic memAck,
    input wire logic [DATA_W-1:0] memRdata,
    // sram pins
    output logic [CADDR_W-1:0] cache_addr_bus,
    output logic [DATA_W-1:0] cacheDataOut,
    output logic cacheDataOe_n,
    input wire logic [DATA_W-1:0] cacheDataIn,
    output logic cache_write_strobe_n,
    output logic cache_read_strobe_n,
    output logic cache_upper_byte_select_n,
    output logic cache_lower_byte_select_n
);

    // ****************************************************************
    // storage and request state
    // ****************************************************************
    // flop-based tag store: large, but every way is read in one cycle
    logic [TAG_W-1:0] tagMem [TAG_ENTRIES];
    logic [LINES_PER_BLOCK-1:0] validMem [TAG_ENTRIES];
    logic [AGE_W-1:0] ageMem [TAG_ENTRIES];
    state_t state;
    logic cfgEnable;
    logic [1:0] cfgSize;
    logic [1:0] cfgAssoc;
    logic rqWrite;
    logic [ADDR_W-1:0] rqAddr;
    logic [1:0] rqBe;
    logic [DATA_W-1:0] rqWdata;
    logic [LOC_W-1:0] fillLoc;
    logic fillReplace;
    logic [1:0] readCnt;
    logic [DATA_W-1:0] dinMeta;
    logic [DATA_W-1:0] dinSync;

    logic [TAG_W-1:0] blockAddr;
    logic [LINE_W-1:0] lineIdx;
    logic [1:0] sizeSel;
    logic [1:0] assocSel;
    logic [3:0] log2Sets;
    logic [2:0] wayCount;
    logic [LOC_W-1:0] setMask;
    logic [LOC_W-1:0] wayLoc [MAX_WAYS];
    logic [TAG_W-1:0] wayTag [MAX_WAYS];
    logic [AGE_W-1:0] wayAge [MAX_WAYS];
    logic [AGE_W-1:0] nextAges [MAX_WAYS];
    logic [MAX_WAYS-1:0] wayLineValid;
    logic [MAX_WAYS-1:0] wayAnyValid;
    logic hit;
    logic [1:0] hitWay;
    logic [1:0] victimWay;
    logic victimHasBlock;
    logic [1:0] touchWay;
    logic lookupHit;
    logic goMem;
    logic fillNow;
    logic cfgChange;

    // ****************************************************************
    // address remap
    // ****************************************************************
    assign blockAddr = rqAddr[ADDR_W-1:BLOCK_LSB];
    assign lineIdx = rqAddr[BLOCK_LSB-1:LINE_LSB];
    // reserved encodings fall back to the largest setting
    assign sizeSel = (cfgSize > SIZE_64K) ? SIZE_64K : cfgSize;
    assign assocSel = (cfgAssoc > ASSOC_FOUR) ? ASSOC_FOUR : cfgAssoc;
    // sets = blocks / ways; ways stack above the set index
    assign log2Sets = 4'(LOG2_BLOCKS_MIN) + {2'h0, sizeSel} - {2'h0, assocSel};
    assign wayCount = 3'h1 << assocSel;
    assign setMask = LOC_W'((12'h001 << log2Sets) - 12'h001);

    always_comb begin
        for (int w = 0; w < MAX_WAYS; w++) begin
            // direct mode: one way, so one location per address
            wayLoc[w] = (LOC_W'(w) << log2Sets) | (blockAddr[LOC_W-1:0] & setMask);
            wayTag[w] = tagMem[wayLoc[w]];
            wayAge[w] = ageMem[wayLoc[w]];
            wayLineValid[w] = validMem[wayLoc[w]][lineIdx];
            wayAnyValid[w] = |validMem[wayLoc[w]];
        end
    end

    cache_way_select u_way_select (
        .wayTag(wayTag),
        .wayLineValid(wayLineValid),
        .wayAnyValid(wayAnyValid),
        .wayAge(wayAge),
        .wayCount(wayCount),
        .reqTag(blockAddr),
        .hit(hit),
        .hitWay(hitWay),
        .victimWay(victimWay),
        .victimHasBlock(victimHasBlock)
    );

    assign touchWay = (state == ST_CHECK) ? hitWay : victimWay;

    cache_lru_update u_lru (
        .ages(wayAge),
        .touchWay(touchWay),
        .wayCount(wayCount),
        .nextAges(nextAges)
    );

    // ****************************************************************
    // control decisions
    // ****************************************************************
    assign lookupHit = cfgEnable && hit;
    assign goMem = rqWrite || !lookupHit;
    assign fillNow = (state == ST_MEM) && memAck && !rqWrite && cfgEnable;
    assign cfgChange = (cacheSize != cfgSize) || (assocMode != cfgAssoc);
    assign reqReady = (state == ST_IDLE);
    // combinational so a miss reaches memory in the lookup cycle itself
    assign memReqValid = ((state == ST_CHECK) && goMem) || (state == ST_MEM);
    assign memWrite = rqWrite;
    assign memAddr = rqAddr;
    assign memByteEn = rqBe;
    assign memWdata = rqWdata;

    // ****************************************************************
    // configuration, taken only between requests
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfgEnable <= RESET_ENABLE;
            cfgSize <= RESET_SIZE;
            cfgAssoc <= RESET_ASSOC;
        end else if (state == ST_IDLE && !reqValid) begin
            cfgEnable <= cacheEnable;
            cfgSize <= cacheSize;
            cfgAssoc <= assocMode;
        end
    end

    // ****************************************************************
    // request sequencing
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            readCnt <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (reqValid) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    readCnt <= 2'h0;
                    state <= goMem ? ST_MEM : ST_SRAM_RD;
                end
                ST_SRAM_RD: begin
                    readCnt <= readCnt + 2'h1;
                    if (readCnt == SRAM_READ_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                ST_MEM: begin
                    if (memAck) begin
                        state <= fillNow ? ST_FILL : ST_IDLE;
                    end
                end
                ST_FILL: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rqWrite <= 1'b0;
            rqAddr <= '0;
            rqBe <= 2'h0;
            rqWdata <= '0;
            fillLoc <= '0;
            fillReplace <= 1'b0;
        end else if (state == ST_IDLE && reqValid) begin
            rqWrite <= reqWrite;
            rqAddr <= reqAddr;
            rqBe <= reqByteEn;
            rqWdata <= reqWdata;
        end else if (state == ST_CHECK) begin
            fillLoc <= wayLoc[victimWay];
            fillReplace <= !victimHasBlock;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            respValid <= 1'b0;
            respHit <= 1'b0;
            respData <= '0;
        end else begin
            respValid <= 1'b0;
            respHit <= 1'b0;
            if (state == ST_SRAM_RD && readCnt == SRAM_READ_LAST) begin
                respValid <= 1'b1;
                respHit <= 1'b1;
                respData <= dinSync;
            end else if (state == ST_MEM && memAck) begin
                respValid <= 1'b1;
                respData <= rqWrite ? respData : memRdata;
            end
        end
    end

    // ****************************************************************
    // tag store update
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n || (state == ST_IDLE && (cfgChange || !cacheEnable))) begin
            // a remap leaves old tags meaningless, so drop them all
            for (int i = 0; i < TAG_ENTRIES; i++) begin
                validMem[i] <= RESET_VALID;
                ageMem[i] <= RESET_AGE;
            end
        end else if ((state == ST_CHECK && lookupHit) || fillNow) begin
            for (int w = 0; w < MAX_WAYS; w++) begin
                if (3'(w) < wayCount) begin
                    ageMem[wayLoc[w]] <= nextAges[w];
                end
            end
            if (fillNow) begin
                validMem[fillLoc] <= (fillReplace ? RESET_VALID : validMem[fillLoc])
                    | (LINES_PER_BLOCK'(1) << lineIdx);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (fillNow && fillReplace) begin
            tagMem[fillLoc] <= blockAddr;
        end
    end

    // ****************************************************************
    // sram pins
    // ****************************************************************
    // read data pins sit outside the clock domain: two flops first
    always_ff @(posedge clk) begin
        dinMeta <= cacheDataIn;
        dinSync <= dinMeta;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cache_addr_bus <= '0;
            cacheDataOut <= '0;
            cacheDataOe_n <= 1'b1;
            cache_write_strobe_n <= 1'b1;
            cache_read_strobe_n <= 1'b1;
            cache_upper_byte_select_n <= 1'b1;
            cache_lower_byte_select_n <= 1'b1;
        end else if (state == ST_CHECK && lookupHit) begin
            // word address: {way and set, line}
            cache_addr_bus <= CADDR_W'({wayLoc[hitWay], lineIdx});
            cacheDataOut <= rqWdata;
            cacheDataOe_n <= !rqWrite;
            cache_write_strobe_n <= !rqWrite;
            cache_read_strobe_n <= rqWrite;
            cache_upper_byte_select_n <= rqWrite ? !rqBe[1] : 1'b0;
            cache_lower_byte_select_n <= rqWrite ? !rqBe[0] : 1'b0;
        end else if (fillNow) begin
            cache_addr_bus <= CADDR_W'({fillLoc, lineIdx});
            cacheDataOut <= memRdata;
            cacheDataOe_n <= 1'b0;
            cache_write_strobe_n <= 1'b0;
            cache_upper_byte_select_n <= 1'b0;
            cache_lower_byte_select_n <= 1'b0;
        end else if (!(state == ST_SRAM_RD && readCnt != SRAM_READ_LAST)) begin
            // selects drop whenever no sram cycle is due
            cacheDataOe_n <= 1'b1;
            cache_write_strobe_n <= 1'b1;
            cache_read_strobe_n <= 1'b1;
            cache_upper_byte_select_n <= 1'b1;
            cache_lower_byte_select_n <= 1'b1;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_MISS_STARTS_MEM: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ST_CHECK && !lookupHit) |-> memReqValid)
        else $error("miss did not start memory in the lookup cycle");
    AST_HIT_NO_MEM: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ST_CHECK && lookupHit && !rqWrite) |-> (!memReqValid)[*4])
        else $error("read hit started a memory transfer");
    AST_READ_HIT_DATA: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ST_CHECK && lookupHit && !rqWrite) |-> ##4 (respValid && respHit))
        else $error("read hit answer not on time");
    AST_WRITE_THROUGH: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ST_CHECK && rqWrite) |-> (memReqValid && memWrite))
        else $error("write not passed to memory");
    AST_SELECTS_OFF_IN_MEM: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ST_MEM && $past(state) == ST_MEM)
        |-> (cache_upper_byte_select_n && cache_lower_byte_select_n))
        else $error("sram selected during memory access");
    AST_DISABLED_GOES_MEM: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ST_CHECK && !cfgEnable) |=> (state == ST_MEM))
        else $error("disabled cache served a request");
    AST_RESET_CLEAN: assert property (@(posedge clk)
        (reset_n && !$past(reset_n)) |-> (!cfgEnable && cache_read_strobe_n))
        else $error("cache not disabled after reset");
    AST_FILL_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
        fillNow |=> (!cache_write_strobe_n && !cache_upper_byte_select_n
            && !cache_lower_byte_select_n && cache_addr_bus[LINE_W-1:0] == lineIdx))
        else $error("miss fill did not write the sram line");
    AST_STROBES_APART: assert property (@(posedge clk) disable iff (!reset_n)
        !(!cache_write_strobe_n && !cache_read_strobe_n))
        else $error("sram read and write strobes together");
    AST_FILL_THEN_HIT: assert property (@(posedge clk) disable iff (!reset_n)
        fillNow |=> (validMem[$past(fillLoc)][$past(lineIdx)]
            && tagMem[$past(fillLoc)] == $past(blockAddr)))
        else $error("fill did not record tag and line");

    COV_READ_HIT: cover property (@(posedge clk) disable iff (!reset_n)
        state == ST_CHECK && lookupHit && !rqWrite);
    COV_READ_FILL: cover property (@(posedge clk) disable iff (!reset_n) fillNow);
    COV_WRITE_HIT: cover property (@(posedge clk) disable iff (!reset_n)
        state == ST_CHECK && lookupHit && rqWrite);
    COV_FOUR_WAY: cover property (@(posedge clk) disable iff (!reset_n)
        fillNow && cfgAssoc == ASSOC_FOUR && !fillReplace);

endmodule : sram_cache_ctrl

/* tb/sram_chip_model.sv */
/*
 * behavioural model of the external sram array behind the cache pins.
 * assumes registered active-low strobes and selects from the controller.
 */
`timescale 1ns/10ps
module sram_chip_model #(
    parameter real ACCESS_NS = 2.0
) (
    // clock
    input wire logic clk,
    // sram pins
    input wire logic [15:0] cache_addr_bus,
    input wire logic [15:0] cacheDataOut,
    input wire logic cacheDataOe_n,
    input wire logic cache_write_strobe_n,
    input wire logic cache_read_strobe_n,
    input wire logic cache_upper_byte_select_n,
    input wire logic cache_lower_byte_select_n,
    output logic [15:0] cacheDataIn
);
    logic [15:0] store [65536];
    logic [15:0] lastOut = 16'h0000;
    logic [15:0] wd;
    logic driving;
    // sram drives only when read strobe and a select are low
    assign driving = !cache_read_strobe_n && !(cache_upper_byte_select_n && cache_lower_byte_select_n);
    // floating pins show the inverse of the last word, so stale data never matches
    assign #(ACCESS_NS) cacheDataIn = driving ? store[cache_addr_bus] : ~lastOut;
    // an undriven data bus writes garbage, as a real chip would
    assign wd = cacheDataOe_n ? ~cacheDataOut : cacheDataOut;
    always @(posedge clk) begin
        if (driving) begin
            lastOut <= store[cache_addr_bus];
        end
        if (!cache_write_strobe_n && !cache_upper_byte_select_n) begin
            store[cache_addr_bus][15:8] <= wd[15:8];
        end
        if (!cache_write_strobe_n && !cache_lower_byte_select_n) begin
            store[cache_addr_bus][7:0] <= wd[7:0];
        end
    end
endmodule : sram_chip_model

/* tb/tb_sram_cache_ctrl.sv */
/*
 * self-checking bench for the sram cache controller.
 * assumes the sram model and a main memory that waits two cycles per request.
 */
`timescale 1ns/10ps
module tb_sram_cache_ctrl import cache_ctrl_pkg::*; ;
    localparam logic [ADDR_W-1:0] ADDR_A = 25'h0001002;
    localparam logic [ADDR_W-1:0] ADDR_B = 25'h0003002;
    localparam logic [ADDR_W-1:0] ADDR_C = 25'h0005002;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cacheEnable = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, memAck = 1'b0;
    logic [1:0] cacheSize = SIZE_16K, assocMode = ASSOC_DIRECT, reqByteEn = 2'h3;
    logic [ADDR_W-1:0] reqAddr = 25'h0000000;
    logic [DATA_W-1:0] reqWdata = 16'h0000, memRdata = 16'h0000;
    logic reqReady, respValid, respHit, memReqValid, memWrite, cacheDataOe_n;
    logic cache_write_strobe_n, cache_read_strobe_n;
    logic cache_upper_byte_select_n, cache_lower_byte_select_n;
    logic [ADDR_W-1:0] memAddr;
    logic [1:0] memByteEn;
    logic [DATA_W-1:0] respData, memWdata, cacheDataOut, cacheDataIn;
    logic [CADDR_W-1:0] cache_addr_bus;
    int miscompares = 0, checked = 0, ackWait = 0;

    always #2.5 clk = ~clk;

    sram_cache_ctrl sram_cache_ctrl_i (.clk, .reset_n, .cacheEnable, .cacheSize, .assocMode,
        .reqValid, .reqReady, .reqWrite, .reqAddr, .reqByteEn, .reqWdata, .respValid,
        .respData, .respHit, .memReqValid, .memWrite, .memAddr, .memByteEn, .memWdata,
        .memAck, .memRdata, .cache_addr_bus, .cacheDataOut, .cacheDataOe_n, .cacheDataIn,
        .cache_write_strobe_n, .cache_read_strobe_n, .cache_upper_byte_select_n,
        .cache_lower_byte_select_n);

    sram_chip_model sram_chip_model_i (.clk, .cache_addr_bus, .cacheDataOut, .cacheDataOe_n,
        .cache_write_strobe_n, .cache_read_strobe_n, .cache_upper_byte_select_n,
        .cache_lower_byte_select_n, .cacheDataIn);

    // ****************************************************************
    // main memory and checking helpers
    // ****************************************************************
    function automatic logic [15:0] memWord(input logic [ADDR_W-1:0] a);
        return a[16:1] ^ 16'hA5C3;
    endfunction : memWord

    // data lines toggle while idle so that only the acked word can match
    always @(posedge clk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (memReqValid && !memAck) begin
            ackWait <= ackWait + 1;
            if (ackWait == 2) begin
                memAck <= 1'b1;
                memRdata <= memWord(memAddr);
                ackWait <= 0;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [1:0] be,
            input logic [15:0] wd, input logic hit, input logic [15:0] expD, input int expWr);
        int n;
        int memAt;
        int wrCycles;
        memAt = 0;
        wrCycles = 0;
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqByteEn <= be;
        reqWdata <= wd;
        @(posedge clk);
        reqValid <= 1'b0;
        #1;
        n = 1;
        forever begin
            if (memReqValid && memAt == 0) begin
                memAt = n;
                chk({memWrite, memAddr}, {wr, a});
                if (wr) chk({memByteEn, memWdata}, {be, wd});
            end
            if (!cache_write_strobe_n) wrCycles++;
            else if (memReqValid) chk(cache_upper_byte_select_n & cache_lower_byte_select_n, 1);
            if (respValid || n == 40) break;
            @(posedge clk);
            #1;
            n++;
        end
        chk(respValid, 1'b1);
        chk(memAt, hit ? 0 : 1);
        if (hit) chk(n, 5);
        if (!wr) chk({respHit, respData}, {hit, expD});
        chk(wrCycles, expWr);
    endtask : acc

    task automatic rd(input logic [ADDR_W-1:0] a, input logic hit, input int expWr);
        acc(1'b0, a, 2'h3, 16'h0000, hit, memWord(a), expWr);
    endtask : rd

    task automatic cfg(input logic en, input logic [1:0] sz, input logic [1:0] as);
        @(posedge clk);
        cacheEnable <= en;
        cacheSize <= sz;
        assocMode <= as;
        repeat (3) @(posedge clk);
        #1;
    endtask : cfg

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        chk({reqReady, respValid, memReqValid, cacheDataOe_n}, 4'h9);
        chk({cache_write_strobe_n, cache_read_strobe_n}, 2'h3);
        chk({cache_upper_byte_select_n, cache_lower_byte_select_n}, 2'h3);
        rd(ADDR_A, 1'b0, 0);
    endtask : t_reset

    task automatic t_direct;
        cfg(1'b1, SIZE_16K, ASSOC_DIRECT);
        rd(ADDR_A, 1'b0, 1);
        rd(ADDR_A, 1'b1, 0);
        rd(ADDR_C, 1'b0, 1);
        rd(ADDR_A, 1'b0, 1);
    endtask : t_direct

    task automatic t_write;
        acc(1'b1, ADDR_A, 2'h2, 16'hBEEF, 1'b0, 16'h0000, 1);
        acc(1'b1, ADDR_A, 2'h1, 16'h12EF, 1'b0, 16'h0000, 1);
        acc(1'b0, ADDR_A, 2'h3, 16'h0000, 1'b1, 16'hBEEF, 0);
        acc(1'b1, 25'h0007002, 2'h3, 16'h1234, 1'b0, 16'h0000, 0);
    endtask : t_write

    task automatic t_assoc;
        cfg(1'b1, SIZE_16K, ASSOC_TWO);
        rd(ADDR_A, 1'b0, 1);
        rd(ADDR_B, 1'b0, 1);
        rd(ADDR_A, 1'b1, 0);
        rd(ADDR_C, 1'b0, 1);
        rd(ADDR_A, 1'b1, 0);
        rd(ADDR_B, 1'b0, 1);
        cfg(1'b1, SIZE_64K, ASSOC_FOUR);
        rd(ADDR_A, 1'b0, 1);
        rd(ADDR_C, 1'b0, 1);
        rd(ADDR_A, 1'b1, 0);
        rd(ADDR_C, 1'b1, 0);
        cfg(1'b0, SIZE_64K, ASSOC_FOUR);
        rd(ADDR_A, 1'b0, 0);
    endtask : t_assoc

    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        t_reset();
        t_direct();
        t_write();
        t_assoc();
        final_report();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule : tb_sram_cache_ctrl
